// ### usb_cfg_defs.svh
`ifndef USB_CFG_DEFS_SVH
`define USB_CFG_DEFS_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define CFG_OFS_PORT0      8'h00
`define CFG_OFS_PORT1      8'h02
`define CFG_OFS_PIN        8'h0E

// ********************************************************************
// field positions of system_config_port0
// ********************************************************************
`define CFG0_CRYSTAL_FREQ_SELECT_HI       15
`define CFG0_CRYSTAL_FREQ_SELECT_LO       14
`define CFG0_OSC_EN        13
`define CFG0_PLL_EN        11
`define CFG0_UCLK_EN       10
`define CFG0_HS_EN         7
`define CFG0_ROLE          6
`define CFG0_PD            5
`define CFG0_PU            4
`define CFG0_USB_EN        0
`define CFG0_WMASK         16'hECF1

// ********************************************************************
// field positions of system_config_port1
// ********************************************************************
`define CFG1_BUSY          12

// ********************************************************************
// reset values
// ********************************************************************
`define CFG0_RESET         16'h0000
`define PIN_CFG_RESET      16'h0000

// ********************************************************************
// pll multiplication factors per crystal choice
// ********************************************************************
`define PLL_MULT_12M       3'h4
`define PLL_MULT_24M       3'h2
`define PLL_MULT_48M       3'h1
`define PLL_MULT_NONE      3'h0

`endif

// ### usb_cfg_pkg.sv
package usb_cfg_pkg;

	// crystal frequency selection codes
	typedef enum logic [1:0]
	{
		CRYSTAL_FREQ_SELECT_12M = 2'h0,
		CRYSTAL_FREQ_SELECT_24M = 2'h1,
		CRYSTAL_FREQ_SELECT_48M = 2'h2,
		CRYSTAL_FREQ_SELECT_RSV = 2'h3
	} crystal_freq_select_type;

	// controller role
	typedef enum logic
	{
		ROLE_PERIPH = 1'b0,
		ROLE_HOST   = 1'b1
	} role_type;

	// port speed in use
	typedef enum logic [1:0]
	{
		SPD_NONE = 2'h0,
		SPD_LOW  = 2'h1,
		SPD_FULL = 2'h2,
		SPD_HIGH = 2'h3
	} speed_type;

	// speed negotiation states, one-hot
	typedef enum logic [4:0]
	{
		ST_IDLE  = 5'h01,
		ST_FULL  = 5'h02,
		ST_LOW   = 5'h04,
		ST_NEGOT = 5'h08,
		ST_HIGH  = 5'h10
	} speed_state_type;

endpackage

// ### usb_line_resistor.sv
`timescale 1ns/10ps
module usb_line_resistor
	import usb_cfg_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire usb_cfg_pkg::role_type role_select,
	input  wire logic                line_pulldown_ctrl,
	input  wire logic                dplus_pullup_ctrl,
	output logic                     dp_pullup_oe,
	output logic                     dp_pulldown_oe,
	output logic                     dm_pulldown_oe
);
	logic nxt_pu;
	logic nxt_pd;
	logic pu_ff;
	logic pd_ff;

	// pull-up only as peripheral, pull-downs only as host
	always_comb
	begin
		nxt_pu = dplus_pullup_ctrl && (role_select == ROLE_PERIPH); // [R20]
		nxt_pd = line_pulldown_ctrl && (role_select == ROLE_HOST);  // [R19]
	end

	// registered so the pad enables never glitch
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pu_ff <= 1'b0;
			pd_ff <= 1'b0;
		end
		else
		begin
			pu_ff <= nxt_pu;
			pd_ff <= nxt_pd;
		end
	end

	assign dp_pullup_oe   = pu_ff;   // [R18]
	assign dp_pulldown_oe = pd_ff;   // [R18]
	assign dm_pulldown_oe = pd_ff;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	pullup_follows_a: assert property (               // [R20]
		$fell(dplus_pullup_ctrl) |=> !dp_pullup_oe)
		else $error("pull-up not released after control fell");
	pulldown_host_a: assert property (                // [R19]
		(line_pulldown_ctrl && role_select == ROLE_HOST)
		|=> (dp_pulldown_oe && dm_pulldown_oe))
		else $error("host pull-downs not applied");
endmodule

// ### usb_speed_select.sv
`timescale 1ns/10ps
module usb_speed_select
	import usb_cfg_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  enable,
	input  wire usb_cfg_pkg::role_type role_select,
	input  wire logic                  high_speed_enable,
	input  wire logic                  bus_reset_seen,
	input  wire logic                  handshake_hs_ok,
	input  wire logic                  handshake_fail,
	input  wire logic                  lowspeed_attach,
	output usb_cfg_pkg::speed_type     port_speed,
	output logic                       handshake_active
);
	speed_state_type state_ff;
	speed_state_type nxt_state;
	logic            host;

	assign host = (role_select == ROLE_HOST);

	// speed negotiation; low speed exists only in host role
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE:
				if (host && lowspeed_attach)
					nxt_state = ST_LOW;                     // [R11]
				else
					nxt_state = ST_FULL;                    // [R10]
			ST_FULL, ST_LOW:
				if (high_speed_enable && bus_reset_seen)
					nxt_state = ST_NEGOT;                   // [R10] [R11]
			ST_NEGOT:
				if (handshake_hs_ok)
					nxt_state = ST_HIGH;
				else if (handshake_fail)
					nxt_state = ST_FULL;
			ST_HIGH:
				if (!high_speed_enable)
					nxt_state = ST_FULL;
				else if (bus_reset_seen)
					nxt_state = ST_NEGOT;
			default:
				nxt_state = ST_IDLE;
		endcase
		if (!enable)
			nxt_state = ST_IDLE;                            // [R22]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// speed code straight from the one-hot state
	always_comb
	begin
		unique case (state_ff)
			ST_LOW:  port_speed = SPD_LOW;
			ST_FULL: port_speed = SPD_FULL;
			ST_HIGH: port_speed = SPD_HIGH;
			ST_NEGOT: port_speed = SPD_FULL;
			default: port_speed = SPD_NONE;
		endcase
	end
	assign handshake_active = (state_ff == ST_NEGOT);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	no_hs_off_a: assert property (                    // [R10]
		(!high_speed_enable && !handshake_active) |=> port_speed != SPD_HIGH)
		else $error("high speed without high-speed enable");
	ls_host_only_a: assert property (                 // [R11]
		(port_speed == SPD_LOW) |-> host)
		else $error("low speed in peripheral role");
endmodule

// ### usb_system_config_control.sv
// Functional notes
// (R01) pll multiplier follows the crystal frequency selection field
// (R02) crystal codes: 00 12MHz, 01 24MHz, 10 48MHz, 11 reserved
// (R03) software sets crystal field after reset, never while running
// (R04) oscillation buffer runs exactly while its enable bit is 1
// (R05) no clearing osc enable while busy; writing 1 ends restoration
// (R06) auto-clock busy flag reads 1 during restoration, else 0
// (R07) 48MHz pll runs exactly while pll enable bit is 1
// (R08) usb block clock supplied only while usb clock enable is 1
// (R09) with usb clock off only 00H, 02H, 0EH writable; reads always
// (R10) peripheral: full speed unless high-speed enable, then handshake
// (R11) host: low/full speed, or handshake picks high or full speed
// (R12) host software clears high-speed enable on low-speed attach
// (R13) host changes high-speed enable between attach and bus reset
// (R14) peripheral changes high-speed enable only with pull-up off
// (R15) controller acts as host or peripheral per role select
// (R16) role select 0 is peripheral, 1 is host
// (R17) role select changes only with both resistor controls 0
// (R18) resistor decode 00 open, 01 D+ up, 10 both down; no 11
// (R19) host role with pull-down bit 1 pulls both lines down
// (R20) peripheral pull-up bit drives D+ pull-up; falling releases it
// (R21) software sets pull-up as peripheral, pull-down as host
// (R22) usb enable bit enables or disables the whole usb block
// (R23) usb enable falling clears role-dependent state fields
// (R24) usb enable changes only while usb clock enable is 1
// (R25) host enables pull-downs and waits for stable lines first
// (R26) unassigned bits read 0, writes to them ignored
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "usb_cfg_defs.svh"
module usb_system_config_control
	import usb_cfg_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [15:0]       reg_wr_data,
	input  wire logic              reg_wr_stb,
	input  wire logic              reg_rd_stb,
	output logic [15:0]            reg_rd_data,
	output logic                   ext_wr_stb,
	input  wire logic [15:0]       ext_rd_data,
	input  wire logic              restore_start,
	input  wire logic              clock_restored,
	input  wire logic              bus_reset_seen,
	input  wire logic              handshake_hs_ok,
	input  wire logic              handshake_fail,
	input  wire logic              lowspeed_attach,
	output logic                   osc_buffer_run,
	output logic                   pll_run,
	output logic [2:0]             pll_multiplier,
	output logic                   usb_clock_gate,
	output logic                   usb_block_enable,
	output usb_cfg_pkg::role_type  role_select,
	output usb_cfg_pkg::speed_type port_speed,
	output logic                   handshake_active,
	output logic                   dp_pullup_oe,
	output logic                   dp_pulldown_oe,
	output logic                   dm_pulldown_oe,
	output logic                   clr_periph_state,
	output logic                   clr_host_state,
	output logic                   auto_clock_busy,
	output logic [15:0]            pin_config
);
	import usb_cfg_pkg::*;

	// ****************************************************************
	// address decode
	// ****************************************************************
	logic        hit_cfg0;
	logic        hit_cfg1;
	logic        hit_pin;
	logic        hit_own;
	logic        wr_cfg0;
	logic        wr_pin;

	assign hit_cfg0 = (reg_addr == `CFG_OFS_PORT0);
	assign hit_cfg1 = (reg_addr == `CFG_OFS_PORT1);
	assign hit_pin  = (reg_addr == `CFG_OFS_PIN);
	assign hit_own  = hit_cfg0 || hit_cfg1 || hit_pin;
	// own registers stay writable with the usb clock off
	assign wr_cfg0  = reg_wr_stb && hit_cfg0;      // [R09]
	assign wr_pin   = reg_wr_stb && hit_pin;       // [R09]

	// ****************************************************************
	// configuration register state
	// ****************************************************************
	logic [15:0] cfg0_ff;
	logic [15:0] nxt_cfg0;
	logic [15:0] pin_ff;
	logic [15:0] nxt_pin;
	logic        busy_ff;
	logic        nxt_busy;
	logic        clr_p_ff;
	logic        nxt_clr_p;
	logic        clr_h_ff;
	logic        nxt_clr_h;
	logic [15:0] rd_ff;
	logic [15:0] nxt_rd;
	logic        en_fall;
	logic        osc_set_wr;

	// unassigned positions are masked off on every write
	always_comb
	begin
		nxt_cfg0 = cfg0_ff;
		if (wr_cfg0)
			nxt_cfg0 = reg_wr_data & `CFG0_WMASK;         // [R26]
		nxt_pin = pin_ff;
		if (wr_pin)
			nxt_pin = reg_wr_data;
	end

	assign en_fall    = cfg0_ff[`CFG0_USB_EN] && !nxt_cfg0[`CFG0_USB_EN];
	assign osc_set_wr = wr_cfg0 && reg_wr_data[`CFG0_OSC_EN];

	// restoration flag: a start in the same cycle as an end wins
	always_comb
	begin
		nxt_busy = busy_ff;
		if ((clock_restored && cfg0_ff[`CFG0_UCLK_EN]) || osc_set_wr)
			nxt_busy = 1'b0;                              // [R05] [R06]
		if (restore_start)
			nxt_busy = 1'b1;                              // [R06]
	end

	// one-cycle clear pulses qualified by the current role
	always_comb
	begin
		nxt_clr_p = en_fall && !cfg0_ff[`CFG0_ROLE];      // [R23]
		nxt_clr_h = en_fall && cfg0_ff[`CFG0_ROLE];       // [R23]
	end

	// read data are valid only in the cycle after the strobe
	always_comb
	begin
		nxt_rd = 16'h0000;
		if (reg_rd_stb)
		begin
			if (hit_cfg0)
				nxt_rd = cfg0_ff;                         // [R26]
			else if (hit_cfg1)
				nxt_rd = {3'h0, busy_ff, 12'h000};        // [R06]
			else if (hit_pin)
				nxt_rd = pin_ff;
			else
				nxt_rd = ext_rd_data;                     // [R09]
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cfg0_ff  <= `CFG0_RESET;
			pin_ff   <= `PIN_CFG_RESET;
			busy_ff  <= 1'b0;
			clr_p_ff <= 1'b0;
			clr_h_ff <= 1'b0;
			rd_ff    <= 16'h0000;
		end
		else
		begin
			cfg0_ff  <= nxt_cfg0;
			pin_ff   <= nxt_pin;
			busy_ff  <= nxt_busy;
			clr_p_ff <= nxt_clr_p;
			clr_h_ff <= nxt_clr_h;
			rd_ff    <= nxt_rd;
		end
	end

	// ****************************************************************
	// clock controls and role outputs
	// ****************************************************************
	crystal_freq_select_type    crystal_freq_select_sel;
	logic [2:0]  mult;

	assign crystal_freq_select_sel = crystal_freq_select_type'(cfg0_ff[`CFG0_CRYSTAL_FREQ_SELECT_HI:`CFG0_CRYSTAL_FREQ_SELECT_LO]);

	// reserved crystal code leaves the pll with no factor
	always_comb
	begin
		unique case (crystal_freq_select_sel)
			CRYSTAL_FREQ_SELECT_12M: mult = `PLL_MULT_12M;               // [R01] [R02]
			CRYSTAL_FREQ_SELECT_24M: mult = `PLL_MULT_24M;               // [R02]
			CRYSTAL_FREQ_SELECT_48M: mult = `PLL_MULT_48M;               // [R02]
			CRYSTAL_FREQ_SELECT_RSV: mult = `PLL_MULT_NONE;
		endcase
	end

	assign pll_multiplier   = mult;
	assign osc_buffer_run   = cfg0_ff[`CFG0_OSC_EN];      // [R04]
	assign pll_run          = cfg0_ff[`CFG0_PLL_EN];      // [R07]
	assign usb_clock_gate   = cfg0_ff[`CFG0_UCLK_EN];     // [R08]
	assign usb_block_enable = cfg0_ff[`CFG0_USB_EN];      // [R22]
	assign role_select      = role_type'(cfg0_ff[`CFG0_ROLE]); // [R15] [R16]
	assign auto_clock_busy  = busy_ff;
	assign pin_config       = pin_ff;
	assign clr_periph_state = clr_p_ff;
	assign clr_host_state   = clr_h_ff;
	assign reg_rd_data      = rd_ff;
	// foreign writes pass only while the usb block has its clock
	assign ext_wr_stb = reg_wr_stb && !hit_own
		&& cfg0_ff[`CFG0_UCLK_EN];                        // [R09]

	// ****************************************************************
	// port line resistors and speed selection
	// ****************************************************************
	usb_line_resistor u_resistor
	(
		.sys_clk            (sys_clk),
		.rst                (rst),
		.role_select        (role_select),
		.line_pulldown_ctrl (cfg0_ff[`CFG0_PD]),
		.dplus_pullup_ctrl  (cfg0_ff[`CFG0_PU]),
		.dp_pullup_oe       (dp_pullup_oe),
		.dp_pulldown_oe     (dp_pulldown_oe),
		.dm_pulldown_oe     (dm_pulldown_oe)
	);

	usb_speed_select u_speed
	(
		.sys_clk           (sys_clk),
		.rst               (rst),
		.enable            (cfg0_ff[`CFG0_USB_EN]),
		.role_select       (role_select),
		.high_speed_enable (cfg0_ff[`CFG0_HS_EN]),
		.bus_reset_seen    (bus_reset_seen),
		.handshake_hs_ok   (handshake_hs_ok),
		.handshake_fail    (handshake_fail),
		.lowspeed_attach   (lowspeed_attach),
		.port_speed        (port_speed),
		.handshake_active  (handshake_active)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence cfg0_write_s;
		reg_wr_stb && hit_cfg0;
	endsequence

	sequence enable_drop_s;
		cfg0_write_s ##0 (usb_block_enable && !reg_wr_data[`CFG0_USB_EN]);
	endsequence

	pll_factor_a: assert property (                   // [R01]
		cfg0_write_s ##0 (reg_wr_data[15:14] == 2'h1)
		|=> pll_multiplier == 3'h2)
		else $error("pll factor wrong for 24MHz crystal");

	osc_follow_a: assert property (                   // [R04]
		cfg0_write_s |=> osc_buffer_run == $past(reg_wr_data[13]))
		else $error("oscillation buffer does not follow its bit");

	pll_follow_a: assert property (                   // [R07]
		cfg0_write_s |=> pll_run == $past(reg_wr_data[11]))
		else $error("pll run does not follow its bit");

	clk_gate_a: assert property (                     // [R08]
		cfg0_write_s |=> usb_clock_gate == $past(reg_wr_data[10]))
		else $error("usb clock gate does not follow its bit");

	write_block_a: assert property (                  // [R09]
		!usb_clock_gate |-> !ext_wr_stb)
		else $error("foreign write passed with usb clock off");

	read_path_a: assert property (                    // [R09]
		(reg_rd_stb && hit_cfg0) |=> reg_rd_data == $past(cfg0_ff))
		else $error("config read returned wrong data");

	unused_zero_a: assert property (                  // [R26]
		(cfg0_ff & ~`CFG0_WMASK) == 16'h0000)
		else $error("unassigned config bit is set");

	enable_clear_a: assert property (                 // [R23]
		enable_drop_s |=> (clr_periph_state != clr_host_state)
		##1 (!clr_periph_state && !clr_host_state))
		else $error("role state clear pulse missing or too long");

	busy_end_a: assert property (                     // [R05]
		(cfg0_write_s ##0 reg_wr_data[13] && !restore_start)
		|=> !auto_clock_busy)
		else $error("writing osc enable did not end restoration");

	busy_set_a: assert property (                     // [R06]
		restore_start |=> auto_clock_busy)
		else $error("restoration start lost");

	role_map_a: assert property (                     // [R16]
		cfg0_write_s |=> (role_select == ROLE_HOST)
		== $past(reg_wr_data[6]))
		else $error("role select encoding wrong");

	speed_idle_a: assert property (                   // [R22]
		!usb_block_enable ##1 !usb_block_enable |-> port_speed == SPD_NONE)
		else $error("port speed active while usb disabled");
endmodule

// ### usb_bus_partner.sv
`timescale 1ns/10ps
// ********************************************************************
// far side of the port: answers the reset handshake
// ********************************************************************
module usb_bus_partner
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic reset_req,
	input  wire logic hs_capable,
	input  wire logic ls_device,
	input  wire logic handshake_active,
	output logic      bus_reset_seen,
	output logic      handshake_hs_ok,
	output logic      handshake_fail,
	output logic      lowspeed_attach
);
	logic [3:0] wait_ff;

	// a low-speed device is a steady level on the lines
	assign lowspeed_attach = ls_device;

	// answer some cycles into the handshake, not at once, so a design
	// that samples the result too early is caught; a full-speed-only
	// device never chirps, which the controller sees as a failure
	always_ff @(posedge sys_clk)
	begin
		bus_reset_seen <= reset_req & ~rst;
		handshake_hs_ok <= 1'b0;
		handshake_fail <= 1'b0;
		if (rst || !handshake_active)
			wait_ff <= 4'h0;
		else if (wait_ff != 4'h6)
			wait_ff <= wait_ff + 4'h1;
		if (!rst && handshake_active && wait_ff == 4'h5)
		begin
			handshake_hs_ok <= hs_capable;
			handshake_fail <= ~hs_capable;
		end
	end
endmodule

// ### usb_system_config_control_test.sv
`timescale 1ns/10ps
module usb_system_config_control_test;
	import usb_cfg_pkg::*;

	logic        sys_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wr_data;
	logic        reg_wr_stb;
	logic        reg_rd_stb;
	logic [15:0] reg_rd_data;
	logic        ext_wr_stb;
	logic [15:0] ext_rd_data;
	logic        restore_start;
	logic        clock_restored;
	logic        bus_reset_seen;
	logic        handshake_hs_ok;
	logic        handshake_fail;
	logic        lowspeed_attach;
	logic        osc_buffer_run;
	logic        pll_run;
	logic [2:0]  pll_multiplier;
	logic        usb_clock_gate;
	logic        usb_block_enable;
	role_type    role_select;
	speed_type   port_speed;
	logic        handshake_active;
	logic        dp_pullup_oe;
	logic        dp_pulldown_oe;
	logic        dm_pulldown_oe;
	logic        clr_periph_state;
	logic        clr_host_state;
	logic        auto_clock_busy;
	logic [15:0] pin_config;
	logic        reset_req;
	logic        hs_capable;
	logic        ls_device;
	logic        ext_seen;
	int          mismatches;
	int          n_tests;
	int          cycle_count;
	int          i;
	logic [2:0]  mult_tab [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
	logic [15:0] clk_tab [3] = '{16'h2000, 16'h0800, 16'h0400};
	logic [2:0]  run_tab [3] = '{3'h4, 3'h2, 3'h1};
	logic [2:0]  clk_runs;
	logic [2:0]  res_oe;

	// grouped outputs keep the compare lines short
	assign clk_runs = {osc_buffer_run, pll_run, usb_clock_gate};
	assign res_oe   = {dp_pullup_oe, dp_pulldown_oe, dm_pulldown_oe};

	usb_system_config_control dut (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_rd_data(reg_rd_data), .ext_wr_stb(ext_wr_stb),
		.ext_rd_data(ext_rd_data), .restore_start(restore_start),
		.clock_restored(clock_restored), .bus_reset_seen(bus_reset_seen),
		.handshake_hs_ok(handshake_hs_ok), .handshake_fail(handshake_fail),
		.lowspeed_attach(lowspeed_attach), .osc_buffer_run(osc_buffer_run),
		.pll_run(pll_run), .pll_multiplier(pll_multiplier),
		.usb_clock_gate(usb_clock_gate), .usb_block_enable(usb_block_enable),
		.role_select(role_select), .port_speed(port_speed),
		.handshake_active(handshake_active), .dp_pullup_oe(dp_pullup_oe),
		.dp_pulldown_oe(dp_pulldown_oe), .dm_pulldown_oe(dm_pulldown_oe),
		.clr_periph_state(clr_periph_state),
		.clr_host_state(clr_host_state),
		.auto_clock_busy(auto_clock_busy), .pin_config(pin_config));

	usb_bus_partner partner (.sys_clk(sys_clk), .rst(rst),
		.reset_req(reset_req), .hs_capable(hs_capable),
		.ls_device(ls_device), .handshake_active(handshake_active),
		.bus_reset_seen(bus_reset_seen), .handshake_hs_ok(handshake_hs_ok),
		.handshake_fail(handshake_fail), .lowspeed_attach(lowspeed_attach));

	// ****************************************************************
	// clock, timeout and bus tasks
	// ****************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge sys_clk)
	begin
		cycle_count++;
		if (cycle_count == 3000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	task wrap_up();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ext_wr_stb is combinational, so it is caught mid-strobe
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_stb <= 1'b1;
		@(negedge sys_clk);
		ext_seen = ext_wr_stb;
		@(posedge sys_clk);
		reg_wr_stb <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task rchk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd_stb <= 1'b1;
		@(posedge sys_clk);
		reg_rd_stb <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rd_data, exp);
	endtask

	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// full speed also shows during negotiation, so wait for its end
	task wait_speed(input speed_type exp);
		for (int k = 0; k < 40
			&& (port_speed !== exp || handshake_active); k++)
			@(negedge sys_clk);
		chk({handshake_active, port_speed}, {1'b0, exp});
	endtask

	task bus_reset(input logic exp_act);
		@(posedge sys_clk);
		reset_req <= 1'b1;
		@(posedge sys_clk);
		reset_req <= 1'b0;
		for (int k = 0; k < 20 && handshake_active !== 1'b1; k++)
			@(negedge sys_clk);
		chk(handshake_active, exp_act);
	endtask

	task restore_pulse();
		@(posedge sys_clk);
		restore_start <= 1'b1;
		@(posedge sys_clk);
		restore_start <= 1'b0;
		cyc(1);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{reg_addr, reg_wr_data, reg_wr_stb, reg_rd_stb} = '0;
		{restore_start, clock_restored, reset_req, hs_capable} = '0;
		{ls_device, mismatches, n_tests, cycle_count} = '0;
		ext_rd_data = 16'h5A3C;
		rst = 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(8'h00, 16'h0000);
		chk(pll_multiplier, 3'h4);
		// crystal choice first, with every clock still off
		for (i = 0; i < 4; i++)
		begin
			wr(8'h00, {i[1:0], 14'h0000});
			cyc(1);
			chk(pll_multiplier, mult_tab[i]);
		end
		wr(8'h00, 16'h130E);
		rchk(8'h00, 16'h0000);
		for (i = 0; i < 3; i++)
		begin
			wr(8'h00, clk_tab[i]);
			cyc(1);
			chk(clk_runs, run_tab[i]);
		end
		wr(8'h10, 16'h1234);
		chk(ext_seen, 1'b1);
		wr(8'h00, 16'h0000);
		wr(8'h10, 16'h1234);
		chk(ext_seen, 1'b0);
		wr(8'h0E, 16'hBEEF);
		cyc(1);
		chk(pin_config, 16'hBEEF);
		rchk(8'h0E, 16'hBEEF);
		rchk(8'h10, 16'h5A3C);
		wr(8'h02, 16'hFFFF);
		rchk(8'h02, 16'h0000);
		// with the block clock off only the buffer bit ends restoration
		restore_pulse();
		chk(auto_clock_busy, 1'b1);
		@(posedge sys_clk);
		clock_restored <= 1'b1;
		cyc(2);
		rchk(8'h02, 16'h1000);
		wr(8'h00, 16'h2000);
		cyc(1);
		chk(auto_clock_busy, 1'b0);
		@(posedge sys_clk);
		clock_restored <= 1'b0;
		wr(8'h00, 16'h2400);
		restore_pulse();
		chk(auto_clock_busy, 1'b1);
		@(posedge sys_clk);
		clock_restored <= 1'b1;
		cyc(2);
		chk(auto_clock_busy, 1'b0);
		@(posedge sys_clk);
		clock_restored <= 1'b0;
		// resistors, peripheral then host
		wr(8'h00, 16'h2410);
		cyc(2);
		chk(res_oe, 3'h4);
		wr(8'h00, 16'h2400);
		cyc(2);
		chk(res_oe, 3'h0);
		wr(8'h00, 16'h2440);
		cyc(1);
		chk(role_select, ROLE_HOST);
		wr(8'h00, 16'h2460);
		cyc(2);
		chk(res_oe, 3'h3);
		// host with a low-speed device, then disable
		@(posedge sys_clk);
		ls_device <= 1'b1;
		wr(8'h00, 16'h2461);
		cyc(1);
		chk(usb_block_enable, 1'b1);
		wait_speed(SPD_LOW);
		wr(8'h00, 16'h2460);
		cyc(1);
		chk({clr_host_state, clr_periph_state}, 2'h2);
		cyc(1);
		chk(clr_host_state, 1'b0);
		wait_speed(SPD_NONE);
		@(posedge sys_clk);
		ls_device <= 1'b0;
		// host with hi-speed negotiation
		wr(8'h00, 16'h24E0);
		wr(8'h00, 16'h24E1);
		wait_speed(SPD_FULL);
		hs_capable <= 1'b1;
		bus_reset(1'b1);
		wait_speed(SPD_HIGH);
		wr(8'h00, 16'h24E0);
		wr(8'h00, 16'h24C0);
		wr(8'h00, 16'h2480);
		cyc(1);
		chk(role_select, ROLE_PERIPH);
		// peripheral negotiation, success then failure
		wr(8'h00, 16'h2490);
		wr(8'h00, 16'h2491);
		wait_speed(SPD_FULL);
		bus_reset(1'b1);
		wait_speed(SPD_HIGH);
		hs_capable <= 1'b0;
		bus_reset(1'b1);
		wait_speed(SPD_FULL);
		wr(8'h00, 16'h2490);
		cyc(1);
		chk({clr_host_state, clr_periph_state}, 2'h1);
		cyc(1);
		chk(clr_periph_state, 1'b0);
		// without hi-speed enable a bus reset starts no handshake
		wr(8'h00, 16'h2480);
		wr(8'h00, 16'h2400);
		wr(8'h00, 16'h2411);
		wait_speed(SPD_FULL);
		bus_reset(1'b0);
		wrap_up();
	end
endmodule
